// *** include/dmr_defines.vh ***
// Constants for the DDR3 init and mode-register block.
// Assumes inclusion by bare name from the design files.
`ifndef DMR_DEFINES_VH
`define DMR_DEFINES_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DMR_OFS_STATUS 8'h00
`define DMR_OFS_CTRL 8'h04
`define DMR_OFS_LAST_ACT 8'h08
`define DMR_OFS_LAST_RW 8'h0C
`define DMR_OFS_MR0 8'h10
`define DMR_OFS_MR3 8'h1C
`define DMR_OFS_LATENCY 8'h20
// ****************************************************************
// Field positions
// ****************************************************************
`define DMR_MR_WR_LO 9
`define DMR_MR_WR_HI 11
`define DMR_MR_DLLRST 8
`define DMR_MR_AP 10
`define DMR_MR_BC 12
`define DMR_MR_DLLDIS 0
// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define DMR_CTRL_RST 32'h0200_0200
`define DMR_DLLK_CYC 16'h0200
`define DMR_ZQINIT_CYC 16'h0200
`define DMR_BL_OTF 2'b01
`define DMR_BL_BC4 2'b10
`define DMR_RESP_OK 2'b00
`define DMR_RESP_ERR 2'b10
`endif

// *** hdl/dmr_mrfile.v ***
// Mode-register store: four words, one write port, registered read.
// Assumes a single clock and that the parent sequences its reads.
`timescale 1ns/1ps
module dmr_mrfile #(
  parameter AW = 2,
  parameter DW = 16
) (
  // Clock
  input wire clk_sys,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // Read port
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  // Storage; no reset, the contents are undefined until written
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ****************************************************************
  // Write and registered read
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // dmr_mrfile

// *** hdl/dmr_core.v ***
// DDR3 device-side init tracker, mode registers and command decode.
// Assumes DDR3 pins already sampled on clk_sys and an AXI4-Lite master.
//
// How it works
// - Each access: one 8n core transfer, four clocks
// - Activate: bank lines pick bank, address picks row
// - Read/write: column, A10 autoprecharge, A12 chop
// - Termination off in reset until CKE registered
// - Mode registers undefined until fully written
// - CAS latency whole clocks; RL is AL plus CL
`timescale 1ns/1ps
`include "dmr_defines.vh"
module dmr_core #(
  parameter RA_W = 14,
  parameter BA_W = 3,
  parameter TRP_CYC = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // DDR3 command pins, sampled at clk_sys
  input wire ddr_reset_n,
  input wire ddr_cke,
  input wire ddr_cs_n,
  input wire ddr_ras_n,
  input wire ddr_cas_n,
  input wire ddr_we_n,
  input wire [BA_W-1:0] ddr_ba,
  input wire [RA_W-1:0] ddr_addr,
  // Device state
  output wire odt_hiz,
  output reg dev_ready,
  output reg core_xfer,
  output reg [1:0] core_beat,
  output reg burst_chop,
  output reg [5:0] read_lat,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // ****************************************************************
  // Command decode
  // ****************************************************************
  reg cke_prev_reg; // CKE seen one clock earlier
  reg cke_seen_reg; // CKE registered high since reset release
  wire cmd_ok = cke_prev_reg & ddr_cke & ddr_reset_n & ~ddr_cs_n;
  wire is_mrs = cmd_ok & ~ddr_ras_n & ~ddr_cas_n & ~ddr_we_n;
  wire is_act = cmd_ok & ~ddr_ras_n & ddr_cas_n & ddr_we_n;
  wire is_rw = cmd_ok & ddr_ras_n & ~ddr_cas_n;
  wire is_zql = cmd_ok & ddr_ras_n & ddr_cas_n & ~ddr_we_n &
    ddr_addr[`DMR_MR_AP];

  // Mode fields held for the datapath
  reg [1:0] bl_mode_reg; // MR0 burst-length field
  reg [3:0] cl_reg; // CAS latency in clocks
  reg [1:0] al_mode_reg; // MR1 additive latency field
  reg [4:0] wr_cyc_reg; // Write recovery in clocks
  reg [3:0] mr_done_reg; // Which mode registers were written
  reg dll_en_reg; // DLL enabled by MR1
  // MR0 DLL reset that the device honours this clock
  wire dll_rst_hit = is_mrs & (ddr_ba[1:0] == 2'd0) &
    ddr_addr[`DMR_MR_DLLRST] & dll_en_reg;
  // Waits after DLL reset and long calibration
  reg [15:0] dll_cnt_reg;
  reg [15:0] zq_cnt_reg;
  reg dll_lock_reg;
  reg zq_done_reg;
  // Last commands, visible to software
  reg [BA_W+RA_W-1:0] last_act_reg;
  reg [31:0] last_rw_reg;
  // Software-set wait counts: [15:0] lock, [31:16] calibration
  reg [31:0] ctrl_reg;

  // Termination released only once CKE registered after reset
  assign odt_hiz = ~ddr_reset_n | ~cke_seen_reg;

  // CL: {A2,A6:A4} with a base of four, integral only
  wire [3:0] cl_dec = {ddr_addr[2], ddr_addr[6:4]} + 4'h4;

  // WR field to clocks; code zero is the largest setting
  reg [4:0] wr_dec;
  always @* begin
    case (ddr_addr[`DMR_MR_WR_HI:`DMR_MR_WR_LO])
      3'd1: wr_dec = 5'd5;
      3'd2: wr_dec = 5'd6;
      3'd3: wr_dec = 5'd7;
      3'd4: wr_dec = 5'd8;
      3'd5: wr_dec = 5'd10;
      3'd6: wr_dec = 5'd12;
      3'd7: wr_dec = 5'd14;
      default: wr_dec = 5'd16;
    endcase
  end

  // Additive latency: 0, CL-1 or CL-2
  reg [3:0] al_val;
  always @* begin
    case (al_mode_reg)
      2'd1: al_val = cl_reg - 4'd1;
      2'd2: al_val = cl_reg - 4'd2;
      default: al_val = 4'd0;
    endcase
  end

  // ****************************************************************
  // Init tracking and mode-register capture
  // ****************************************************************
  // Device reset pin and srst both clear all init progress, so a
  // warm reset restarts from the CKE wait as at power-up.
  always @(posedge clk_sys) begin
    if (srst | ~ddr_reset_n) begin
      cke_prev_reg <= 1'b0;
      cke_seen_reg <= 1'b0;
      mr_done_reg <= 4'h0;
      dll_en_reg <= 1'b0;
      dll_cnt_reg <= 16'h0000;
      zq_cnt_reg <= 16'h0000;
      dll_lock_reg <= 1'b0;
      zq_done_reg <= 1'b0;
      dev_ready <= 1'b0;
      bl_mode_reg <= 2'b00;
      cl_reg <= 4'h4;
      al_mode_reg <= 2'b00;
      wr_cyc_reg <= 5'd16;
    end else begin
      cke_prev_reg <= ddr_cke;
      // First registered-high CKE ends the termination hold
      if (ddr_cke & cke_prev_reg) begin
        cke_seen_reg <= 1'b1;
      end
      // MRS: every field of the addressed register is replaced
      if (is_mrs) begin
        mr_done_reg[ddr_ba[1:0]] <= 1'b1;
        if (ddr_ba[1:0] == 2'd0) begin
          bl_mode_reg <= ddr_addr[1:0];
          cl_reg <= cl_dec;
          wr_cyc_reg <= wr_dec;
          // DLL reset bit is self-clearing: only the wait is kept
          if (ddr_addr[`DMR_MR_DLLRST] & dll_en_reg) begin
            dll_cnt_reg <= ctrl_reg[15:0];
            dll_lock_reg <= 1'b0;
          end
        end
        if (ddr_ba[1:0] == 2'd1) begin
          dll_en_reg <= ~ddr_addr[`DMR_MR_DLLDIS];
          al_mode_reg <= ddr_addr[4:3];
        end
      end
      // Lock wait counts down; a fresh DLL reset reloads it instead
      if (!dll_rst_hit && dll_cnt_reg != 16'h0000) begin
        dll_cnt_reg <= dll_cnt_reg - 16'h0001;
        if (dll_cnt_reg == 16'h0001) begin
          dll_lock_reg <= 1'b1;
        end
      end
      // Long calibration starts its own wait
      if (is_zql) begin
        zq_cnt_reg <= ctrl_reg[31:16];
        zq_done_reg <= 1'b0;
      end else if (zq_cnt_reg != 16'h0000) begin
        zq_cnt_reg <= zq_cnt_reg - 16'h0001;
        if (zq_cnt_reg == 16'h0001) begin
          zq_done_reg <= 1'b1;
        end
      end
      // Ready once all registers are set, DLL locked, ZQ done
      dev_ready <= (mr_done_reg == 4'hF) & dll_lock_reg &
        zq_done_reg;
    end
  end

  // ****************************************************************
  // Access decode and core transfer
  // ****************************************************************
  // One access moves 8n bits over four core clocks; the pins see
  // two n-bit words per clock, so eight beats in all.
  always @(posedge clk_sys) begin
    if (srst) begin
      core_xfer <= 1'b0;
      core_beat <= 2'd0;
      burst_chop <= 1'b0;
      read_lat <= 6'd0;
      last_act_reg <= {(BA_W+RA_W){1'b0}};
      last_rw_reg <= 32'h0000_0000;
    end else begin
      read_lat <= {2'b00, al_val} + {2'b00, cl_reg};
      if (is_act) begin
        last_act_reg <= {ddr_ba, ddr_addr};
      end
      if (is_rw) begin
        // Chop from A12 only in on-the-fly mode, A12 low = chop
        if (bl_mode_reg == `DMR_BL_OTF) begin
          burst_chop <= ~ddr_addr[`DMR_MR_BC];
        end else begin
          burst_chop <= (bl_mode_reg == `DMR_BL_BC4);
        end
        last_rw_reg <= {11'h000, ~ddr_we_n, ddr_addr[`DMR_MR_AP],
          ddr_ba, ddr_addr[9:0], 6'h00};
        core_xfer <= 1'b1;
        core_beat <= 2'd0;
      end else if (core_xfer) begin
        // Four clocks per transfer; a new command restarts it
        core_beat <= core_beat + 2'd1;
        if (core_beat == 2'd3) begin
          core_xfer <= 1'b0;
        end
      end
    end
  end

  // Auto-precharge write delay: WR plus precharge time
  wire [7:0] dal_cyc = {3'b000, wr_cyc_reg} + TRP_CYC[7:0];

  // ****************************************************************
  // Mode-register store
  // ****************************************************************
  wire [15:0] mr_rd;
  dmr_mrfile #(.AW(2), .DW(16)) u_mrfile (
    .clk_sys(clk_sys),
    .wr_en(is_mrs),
    .wr_addr(ddr_ba[1:0]),
    .wr_data({{(16-RA_W){1'b0}}, ddr_addr}),
    .rd_addr(s_axi_araddr[3:2]),
    .rd_data(mr_rd)
  );

  // ****************************************************************
  // AXI4-Lite write side
  // ****************************************************************
  reg aw_hold_reg; // Address taken, waiting for data
  reg w_hold_reg; // Data taken, waiting for address
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  // Take each channel independently while no response is pending
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_reg & ~s_axi_bvalid;
  wire aw_go = s_axi_awvalid & s_axi_awready;
  wire w_go = s_axi_wvalid & s_axi_wready;
  wire [7:0] wa = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wd = w_hold_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] ws = w_hold_reg ? w_strb_reg : s_axi_wstrb;
  wire wr_fire = (aw_hold_reg | aw_go) & (w_hold_reg | w_go);
  integer i;

  // Write sequencer; only the control word is writable
  always @(posedge clk_sys) begin
    if (srst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DMR_RESP_OK;
      ctrl_reg <= `DMR_CTRL_RST;
    end else begin
      if (aw_go) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_go) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wa == `DMR_OFS_CTRL) begin
          s_axi_bresp <= `DMR_RESP_OK;
          for (i = 0; i < 4; i = i + 1) begin
            if (ws[i]) begin
              ctrl_reg[i*8 +: 8] <= wd[i*8 +: 8];
            end
          end
        end else begin
          // Read-only or unmapped
          s_axi_bresp <= `DMR_RESP_ERR;
        end
      end else begin
        if (aw_go) begin
          aw_hold_reg <= 1'b1;
        end
        if (w_go) begin
          w_hold_reg <= 1'b1;
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read side
  // ****************************************************************
  // Two cycles from accept to rvalid: the store's read is registered
  reg rd_pend_reg;
  reg [7:0] ar_addr_reg;
  assign s_axi_arready = ~rd_pend_reg & ~s_axi_rvalid;
  wire [31:0] status_w = {20'h0_0000, dev_ready, zq_done_reg,
    dll_lock_reg, dll_en_reg, mr_done_reg, odt_hiz, cke_seen_reg,
    ddr_reset_n, core_xfer};

  always @(posedge clk_sys) begin
    if (srst) begin
      rd_pend_reg <= 1'b0;
      ar_addr_reg <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DMR_RESP_OK;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        rd_pend_reg <= 1'b1;
        ar_addr_reg <= s_axi_araddr;
      end else if (rd_pend_reg) begin
        rd_pend_reg <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DMR_RESP_OK;
        if (ar_addr_reg == `DMR_OFS_STATUS) begin
          s_axi_rdata <= status_w;
        end else if (ar_addr_reg == `DMR_OFS_CTRL) begin
          s_axi_rdata <= ctrl_reg;
        end else if (ar_addr_reg == `DMR_OFS_LAST_ACT) begin
          s_axi_rdata <= {{(32-BA_W-RA_W){1'b0}}, last_act_reg};
        end else if (ar_addr_reg == `DMR_OFS_LAST_RW) begin
          s_axi_rdata <= last_rw_reg;
        end else if (ar_addr_reg >= `DMR_OFS_MR0 &&
          ar_addr_reg <= `DMR_OFS_MR3 && ar_addr_reg[1:0] == 2'b00) begin
          // Undefined content reads as zero until written
          s_axi_rdata <= mr_done_reg[ar_addr_reg[3:2]] ?
            {16'h0000, mr_rd} : 32'h0000_0000;
        end else if (ar_addr_reg == `DMR_OFS_LATENCY) begin
          s_axi_rdata <= {8'h00, dal_cyc, 3'b000, wr_cyc_reg,
            2'b00, read_lat};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `DMR_RESP_ERR;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // dmr_core

// *** tb/dmr_core_checker.sv ***
// Concurrent checks on the ports of the DDR3 init and mode core.
// Assumes one clock domain and the core's sync active-high reset.
`timescale 1ns/1ps
module dmr_core_checker (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Command pins
  input wire ddr_reset_n,
  input wire ddr_cke,
  input wire ddr_cs_n,
  input wire ddr_ras_n,
  input wire ddr_cas_n,
  // Device state
  input wire odt_hiz,
  input wire dev_ready,
  input wire core_xfer,
  input wire [1:0] core_beat,
  input wire [5:0] read_lat,
  // Register bus answers
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_odt_in_reset: assert property (!ddr_reset_n |-> odt_hiz)
    else $error("termination active during reset");
  // CKE registered high twice ends the high-impedance hold
  a_odt_cke_seen: assert property (ddr_reset_n && ddr_cke &&
    $past(ddr_cke) && $past(ddr_reset_n) |=> odt_hiz == !ddr_reset_n)
    else $error("termination state wrong after cke");
  a_xfer_start: assert property (ddr_reset_n && ddr_cke &&
    $past(ddr_cke) && !ddr_cs_n && ddr_ras_n && !ddr_cas_n
    |=> core_xfer && core_beat == 2'd0)
    else $error("core transfer did not start");
  a_xfer_beats: assert property ($rose(core_xfer) |->
    core_beat == 2'd0 ##1 core_beat == 2'd1 ##1 core_beat == 2'd2
    ##1 core_beat == 2'd3)
    else $error("core beat order wrong");
  a_xfer_four: assert property ($rose(core_xfer) |->
    core_xfer [*4] ##1 !core_xfer)
    else $error("core transfer not four clocks");
  a_ready_clear: assert property (!ddr_reset_n |=> !dev_ready)
    else $error("ready kept through reset");
  a_lat_default: assert property (!ddr_reset_n [*3] |->
    read_lat == 6'd4)
    else $error("read latency not default in reset");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule // dmr_core_checker

bind dmr_core dmr_core_checker chk_u (
  .clk_sys(clk_sys), .srst(srst), .ddr_reset_n(ddr_reset_n),
  .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
  .ddr_cas_n(ddr_cas_n), .odt_hiz(odt_hiz), .dev_ready(dev_ready),
  .core_xfer(core_xfer), .core_beat(core_beat), .read_lat(read_lat),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// *** tb/dmr_ctl_model.sv ***
// Behavioural DDR3 controller driving the core's command pins.
// Assumes the bench calls one task at a time, right after an edge.
`timescale 1ns/1ps
module dmr_ctl_model #(
  parameter T_INIT = 12500, // 500 us at 40 ns
  parameter T_XPR = 5, // Reset exit, five clocks
  parameter T_MRD = 4, // Gap between mode writes
  parameter T_MOD = 12 // Mode write to any other command
) (
  // Clock
  input wire clk_sys,
  // Command pins
  output reg ddr_reset_n,
  output reg ddr_cke,
  output reg ddr_odt,
  output reg ddr_cs_n,
  output reg ddr_ras_n,
  output reg ddr_cas_n,
  output reg ddr_we_n,
  output reg [2:0] ddr_ba,
  output reg [13:0] ddr_addr
);
  // Power comes up with the device held in reset
  initial begin
    ddr_reset_n = 1'b0;
    ddr_cke = 1'b0;
    ddr_odt = 1'b0;
    {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} = 4'hF;
    ddr_ba = 3'd0;
    ddr_addr = 14'h0000;
  end
  // One command for one clock, then deselect with scrambled lines
  task cmd(input [3:0] c, input [2:0] b, input [13:0] a);
    begin
      @(posedge clk_sys);
      {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= c;
      ddr_ba <= b;
      ddr_addr <= a;
      @(posedge clk_sys);
      {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= 4'hF;
      ddr_ba <= ~b;
      ddr_addr <= ~a;
    end
  endtask
  // Full reset and init walk; hold sets the reset width in clocks
  task power_up(input integer hold, input [13:0] m0, m1, m2, m3);
    begin
      @(posedge clk_sys);
      ddr_reset_n <= 1'b0;
      ddr_cke <= 1'b0;
      // Termination input held low and static through the whole walk
      ddr_odt <= 1'b0;
      repeat (hold) @(posedge clk_sys);
      ddr_reset_n <= 1'b1;
      repeat (T_INIT) @(posedge clk_sys);
      ddr_cke <= 1'b1;
      repeat (T_XPR) @(posedge clk_sys);
      cmd(4'h0, 3'd2, m2);
      repeat (T_MRD) @(posedge clk_sys);
      cmd(4'h0, 3'd3, m3);
      repeat (T_MRD) @(posedge clk_sys);
      cmd(4'h0, 3'd1, m1 & 14'h3FFE);
      repeat (T_MRD) @(posedge clk_sys);
      cmd(4'h0, 3'd0, (m0 & 14'h3F7F) | 14'h0100);
      repeat (T_MOD) @(posedge clk_sys);
      cmd(4'h6, 3'd0, 14'h0400);
    end
  endtask
endmodule // dmr_ctl_model

// *** tb/test_ddr3_init_and_mode_register.sv ***
// Self-checking bench for the DDR3 init and mode-register core.
// Assumes the controller model owns every DDR3 command pin.
`timescale 1ns/1ps
module test_ddr3_init_and_mode_register;
  // ****************************************************************
  // Signals
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic [31:0] exp;
    logic [1:0] resp;
  } dmr_row_t;
  // CL6, WR 7 clocks (covers 15 ns at 40 ns), on-the-fly chop
  localparam [13:0] MR0 = 14'h0721;
  reg clk_sys = 1'b0;
  reg srst = 1'b1;
  wire rst_n, cke, cs_n, ras_n, cas_n, we_n;
  wire [2:0] ba;
  wire [13:0] addr;
  wire odt_hiz, dev_ready, core_xfer, burst_chop;
  wire [1:0] core_beat, bresp, rresp;
  wire [5:0] read_lat;
  wire awready, wready, bvalid, arready, rvalid;
  wire [31:0] rdata;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0;
  integer n_mismatch = 0, checks = 0, i;
  reg [31:0] rd;
  reg [1:0] rsp;
  dmr_row_t rows [0:6];
  always #20 clk_sys = ~clk_sys;
  dmr_ctl_model p_u (.clk_sys(clk_sys), .ddr_reset_n(rst_n), .ddr_odt(),
    .ddr_cke(cke), .ddr_cs_n(cs_n), .ddr_ras_n(ras_n),
    .ddr_cas_n(cas_n), .ddr_we_n(we_n), .ddr_ba(ba), .ddr_addr(addr));
  dmr_core dut_u (.clk_sys(clk_sys), .srst(srst), .ddr_reset_n(rst_n),
    .ddr_cke(cke), .ddr_cs_n(cs_n), .ddr_ras_n(ras_n),
    .ddr_cas_n(cas_n), .ddr_we_n(we_n), .ddr_ba(ba), .ddr_addr(addr),
    .odt_hiz(odt_hiz), .dev_ready(dev_ready), .core_xfer(core_xfer),
    .core_beat(core_beat), .burst_chop(burst_chop), .read_lat(read_lat),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Handshakes are judged in the edge's own step, before the design's
  // registers move; one idle edge follows so no signal is set twice
  task automatic axi_wr(input [7:0] a, input [31:0] d, input [3:0] s);
    reg pa, pw, pb;
    integer k;
    begin
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      k = 0;
      while (k < 50 && (pa || pw || pb)) begin
        @(posedge clk_sys);
        k = k + 1;
        if (pa && awready) begin
          pa = 1'b0;
          awvalid <= 1'b0;
        end
        if (pw && wready) begin
          pw = 1'b0;
          wvalid <= 1'b0;
        end
        if (pb && bvalid) begin
          pb = 1'b0;
          rsp = bresp;
          bready <= 1'b0;
        end
      end
      if (pa || pw || pb) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] axi_wr expected done seen timeout");
      end
      @(posedge clk_sys);
    end
  endtask
  task automatic axi_rd(input [7:0] a);
    reg pa, pr;
    integer k;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      pa = 1'b1;
      pr = 1'b1;
      k = 0;
      while (k < 50 && (pa || pr)) begin
        @(posedge clk_sys);
        k = k + 1;
        if (pa && arready) begin
          pa = 1'b0;
          arvalid <= 1'b0;
        end
        if (pr && rvalid) begin
          pr = 1'b0;
          rd = rdata;
          rsp = rresp;
          rready <= 1'b0;
        end
      end
      if (pa || pr) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] axi_rd expected done seen timeout");
      end
      @(posedge clk_sys);
    end
  endtask
  // Reset and init with a mid-walk look before CKE rises
  task automatic walk(input integer hold);
    begin
      fork
        p_u.power_up(hold, MR0, 14'h0000, 14'h0008, 14'h0000);
        begin
          repeat (hold + 3) @(negedge clk_sys);
          chk("odt_hiz", 1, odt_hiz);
          chk("dev_ready", 0, dev_ready);
          chk("read_lat", 4, read_lat);
        end
      join
      i = 0;
      while (dev_ready !== 1'b1 && i < 200) begin
        @(negedge clk_sys);
        i = i + 1;
      end
      chk("dev_ready", 1, dev_ready);
      chk("odt_hiz", 0, odt_hiz);
      chk("read_lat", 6, read_lat);
      @(posedge clk_sys);
    end
  endtask
  task summarize;
    begin
      if (n_mismatch == 0 && checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    rows[0] = '{1'b0, 8'h04, 32'h0, 4'h0, 32'h0200_0200, 2'b00};
    rows[1] = '{1'b1, 8'h04, 32'h0008_0008, 4'hF, 32'h0, 2'b00};
    rows[2] = '{1'b1, 8'h04, 32'hFFFF_FF05, 4'h1, 32'h0, 2'b00};
    rows[3] = '{1'b0, 8'h04, 32'h0, 4'h0, 32'h0008_0005, 2'b00};
    rows[4] = '{1'b1, 8'h10, 32'h0000_1234, 4'hF, 32'h0, 2'b10};
    rows[5] = '{1'b0, 8'h10, 32'h0, 4'h0, 32'h0, 2'b00};
    rows[6] = '{1'b0, 8'h24, 32'h0, 4'h0, 32'h0, 2'b10};
    repeat (10) @(posedge clk_sys);
    chk("odt_hiz", 1, odt_hiz);
    srst <= 1'b0;
    @(posedge clk_sys);
    for (i = 0; i < 7; i = i + 1) begin
      if (rows[i].wr)
        axi_wr(rows[i].addr, rows[i].data, rows[i].strb);
      else
        axi_rd(rows[i].addr);
      if (!rows[i].wr) chk("rdata", rows[i].exp, rd);
      chk("resp", {30'h0, rows[i].resp}, {30'h0, rsp});
    end
    walk(5000);
    p_u.cmd(4'b0011, 3'd5, 14'h2ABC);
    axi_rd(8'h08);
    chk("last_act", 32'h0001_6ABC, rd);
    p_u.cmd(4'b0101, 3'd3, 14'h05F8);
    repeat (6) @(posedge clk_sys);
    chk("chop", 1, burst_chop);
    axi_rd(8'h0C);
    chk("last_rw", 32'h000B_7E00, rd);
    p_u.cmd(4'b0100, 3'd2, 14'h1010);
    repeat (6) @(posedge clk_sys);
    chk("chop", 0, burst_chop);
    axi_rd(8'h0C);
    chk("last_rw", 32'h0012_0400, rd);
    axi_rd(8'h20);
    chk("latency", 32'h000B_0706, rd & 32'h00FF_1F3F);
    // Idle rewrite: close every bank, let precharge pass, then CL5
    p_u.cmd(4'b0010, 3'd0, 14'h0400);
    repeat (4) @(posedge clk_sys);
    p_u.cmd(4'h0, 3'd0, 14'h0611);
    axi_rd(8'h20);
    chk("latency", 32'h000B_0705, rd & 32'h00FF_1F3F);
    axi_rd(8'h00);
    chk("mr_done", 32'h0000_00F0, rd & 32'h0000_00F0);
    walk(3);
    summarize;
  end
  // Two full init walks need about 30200 clocks
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch = n_mismatch + 1;
    summarize;
  end
endmodule // test_ddr3_init_and_mode_register
